/* core/i2cs_core.sv */
// Byte-level I2C master/slave sequencer with CPU handshake and line control
`timescale 1ns/100ps
`default_nettype none
module i2cs_core
  import i2cs_pkg::*;
#(
  parameter int HALF_STD_CYC = HALF_STD,
  parameter int HALF_FAST_CYC = HALF_FAST
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic block_on,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic ack_en,
  input wire logic gc_en,
  input wire logic irq_on,
  input wire logic ten_bit_mode,
  input wire logic [1:0] bus_speed_bits,
  input wire logic [9:0] own_addr,
  input wire logic sr1_read,
  input wire logic sr2_read,
  input wire logic dr_read,
  input wire logic dr_write,
  input wire logic [7:0] dr_wdata,
  input wire logic cr_write,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic [7:0] dr_rdata,
  output logic master_role_flag,
  output logic address_hit_flag,
  output logic event_pending_flag,
  output logic byte_done_flag,
  output logic stop_seen_flag,
  output logic bus_fault_flag,
  output logic no_reply_flag,
  output logic start_sent_flag,
  output logic tx_mode,
  output logic bus_busy,
  output logic irq
);
  typedef struct packed {
    i2cs_state_type st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] dr;
    logic [1:0] ph;
    logic [1:0] wk;
    logic sr1_seen;
    logic tx;
    logic addr_ph;
    logic hdr_ok;
    logic ten_done;
    logic m10;
    logic mrx;
    logic sel;
    logic hit_pend;
    logic post_wait;
    logic post_ign;
    logic master;
    logic busy;
    logic scl_oe;
    logic sda_oe;
    logic line_lo;
    logic ev_hold;
    logic address_hit;
    logic byte_done;
    logic stop_seen;
    logic bus_fault;
    logic no_reply;
    logic start_sent;
    logic event_p;
    logic irq;
  } i2cs_core_type;

  i2cs_core_type r, n;
  logic start_det, stop_det, scl_rise, scl_fall, tick, run;
  logic wait_done, mid_byte, hdr_match, hit7, ackd, ack_go;

  i2cs_line_mon u_mon (
    .clock(clock),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_det(start_det),
    .stop_det(stop_det),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall)
  );

  // Divider idles while the line is released but still held low elsewhere
  assign run = r.master && (r.st == ST_XFER || r.st == ST_MSTART || r.st == ST_MSTOP) &&
               !(!r.scl_oe && !scl_in);

  i2cs_scl_div #(
    .HALF_STD_CYC(HALF_STD_CYC),
    .HALF_FAST_CYC(HALF_FAST_CYC)
  ) u_div (
    .clock(clock),
    .reset(reset),
    .run(run),
    .bus_speed_bits(bus_speed_bits),
    .tick(tick)
  );

  always_comb begin
    n = r;
    wait_done = 1'b0;
    ack_go = 1'b0;
    // A genuine stop or repeated start always follows one SCL rise, so bit one is exempt
    mid_byte = (r.st == ST_XFER) && (r.cnt > BIT_FIRST) && (r.cnt < BIT_POST);
    hdr_match = ten_bit_mode && (r.sh[7:3] == HDR10) && (r.sh[2:1] == own_addr[9:8]);
    hit7 = !ten_bit_mode && ((r.sh[7:1] == own_addr[6:0]) || (gc_en && r.sh == GC_ADDR));
    ackd = !sda_in;
    // Clears first, so a set in the same cycle wins
    if (sr1_read) begin
      n.address_hit = 1'b0;
      n.sr1_seen = r.sr1_seen || (r.st == ST_WAIT);
    end
    if (sr2_read) begin
      n.stop_seen = 1'b0;
      n.bus_fault = 1'b0;
      n.no_reply = 1'b0;
    end
    if (dr_write) begin
      n.dr = dr_wdata;
    end
    if (start_det) begin
      n.busy = 1'b1;
    end
    if (stop_det) begin
      n.busy = 1'b0;
    end
    if (r.st == ST_WAIT && r.sr1_seen) begin
      case (r.wk)
        WK_SR1: wait_done = 1'b1;
        WK_DRR: wait_done = dr_read;
        WK_DRW: wait_done = dr_write;
        default: wait_done = cr_write;
      endcase
    end
    case (r.st)
      ST_IDLE: begin
        if (start_req && !r.busy) begin
          n.st = ST_MSTART;
          n.master = 1'b1;
          n.ph = PH_REL;
        end
      end
      ST_MSTART: begin
        if (tick) begin
          case (r.ph)
            PH_REL: begin
              n.scl_oe = 1'b0;
              n.ph = PH_MID;
            end
            PH_MID: begin
              n.sda_oe = 1'b1;
              n.ph = PH_END;
            end
            default: begin
              n.scl_oe = 1'b1;
              n.start_sent = 1'b1;
              n.st = ST_WAIT;
              n.wk = WK_DRW;
              n.sr1_seen = 1'b0;
              n.tx = 1'b1;
              n.addr_ph = 1'b1;
              n.m10 = 1'b0;
            end
          endcase
        end
      end
      ST_MSTOP: begin
        if (tick) begin
          case (r.ph)
            PH_REL: begin
              n.sda_oe = 1'b1;
              n.ph = PH_MID;
            end
            PH_MID: begin
              n.scl_oe = 1'b0;
              n.ph = PH_END;
            end
            default: begin
              n.sda_oe = 1'b0;
              n.st = ST_IDLE;
              n.master = 1'b0;
            end
          endcase
        end
      end
      ST_WAIT: begin
        n.scl_oe = 1'b1;
        if ((wait_done && r.master && r.wk == WK_DRR && stop_req) ||
            (r.master && stop_req && r.byte_done && r.wk != WK_DRR)) begin
          n.st = ST_MSTOP;
          n.ph = PH_REL;
          n.sda_oe = 1'b0;
          n.byte_done = 1'b0;
          n.sr1_seen = 1'b0;
        end else if (!r.master && stop_req && r.byte_done) begin
          n.st = ST_IGNORE;
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          n.byte_done = 1'b0;
        end else if (r.master && start_req && r.sr1_seen) begin
          n.st = ST_MSTART;
          n.ph = PH_REL;
          n.sda_oe = 1'b0;
          n.byte_done = 1'b0;
          n.ev_hold = 1'b0;
          n.sr1_seen = 1'b0;
        end else if (wait_done) begin
          n.byte_done = 1'b0;
          n.start_sent = 1'b0;
          n.ev_hold = 1'b0;
          n.sr1_seen = 1'b0;
          if (r.wk == WK_CRW && !r.mrx) begin
            // Address done as transmitter: still hold for the first data byte
            n.wk = WK_DRW;
            n.sr1_seen = 1'b1;
          end else begin
            if (r.wk == WK_CRW) begin
              n.tx = 1'b0;
            end
            n.st = ST_XFER;
            n.cnt = BIT_ZERO;
            n.scl_oe = r.master;
            n.sda_oe = n.tx && !n.dr[7];
            n.sh = {n.dr[6:0], 1'b0};
          end
        end
      end
      ST_XFER: begin
        if (tick) begin
          n.scl_oe = !r.scl_oe;
        end
        if (scl_rise && r.cnt < BIT_ACK) begin
          if (!r.tx) begin
            n.sh = {r.sh[6:0], sda_in};
          end
          n.cnt = r.cnt + 4'h1;
        end else if (scl_rise && r.cnt == BIT_ACK) begin
          n.cnt = BIT_POST;
          if (r.tx) begin
            if (!ackd) begin
              n.no_reply = 1'b1;
              if (r.master) begin
                n.byte_done = 1'b1;
                n.post_wait = 1'b1;
                n.wk = WK_DRW;
              end else begin
                n.post_ign = 1'b1;
              end
            end else if (r.master && r.addr_ph) begin
              n.ev_hold = 1'b1;
              n.post_wait = 1'b1;
              if (ten_bit_mode && r.dr[7:3] == HDR10 && !r.dr[0] && !r.m10) begin
                n.m10 = 1'b1;
                n.wk = WK_DRW;
              end else begin
                n.addr_ph = 1'b0;
                n.mrx = !r.m10 && r.dr[0];
                n.wk = WK_CRW;
              end
            end else begin
              n.byte_done = 1'b1;
              n.post_wait = 1'b1;
              n.wk = WK_DRW;
            end
          end else if (r.hit_pend) begin
            n.address_hit = 1'b1;
            n.sel = 1'b1;
          end else if (r.post_wait) begin
            n.byte_done = 1'b1;
          end
        end else if (scl_fall && r.tx && r.cnt >= BIT_FIRST && r.cnt <= BIT_LAST) begin
          n.sda_oe = !r.sh[7];
          n.sh = {r.sh[6:0], 1'b0};
        end else if (scl_fall && r.cnt == BIT_ACK) begin
          if (r.tx) begin
            n.sda_oe = 1'b0;
          end else begin
            n.dr = r.sh;
            n.post_wait = 1'b1;
            n.wk = WK_DRR;
            ack_go = ack_en;
            if (r.addr_ph && !r.master) begin
              n.wk = WK_SR1;
              if (hdr_match && !r.sh[0]) begin
                n.hdr_ok = 1'b1;
                n.post_wait = 1'b0;
              end else if (hdr_match && r.sh[0] && r.ten_done) begin
                n.hit_pend = 1'b1;
                n.wk = WK_DRW;
              end else if (hit7) begin
                n.hit_pend = 1'b1;
                n.wk = r.sh[0] ? WK_DRW : WK_SR1;
              end else if (ten_bit_mode && r.hdr_ok && r.sh == own_addr[7:0]) begin
                n.hit_pend = 1'b1;
                n.ten_done = 1'b1;
              end else begin
                n.post_wait = 1'b0;
                n.post_ign = 1'b1;
                ack_go = 1'b0;
              end
            end
            n.sda_oe = ack_go;
          end
        end else if (scl_fall && r.cnt == BIT_POST) begin
          n.sda_oe = 1'b0;
          n.hit_pend = 1'b0;
          n.post_wait = 1'b0;
          n.post_ign = 1'b0;
          n.cnt = BIT_ZERO;
          if (r.post_ign) begin
            n.st = ST_IGNORE;
          end else if (r.post_wait) begin
            n.st = ST_WAIT;
            n.scl_oe = 1'b1;
            n.sr1_seen = 1'b0;
            if (r.hit_pend) begin
              n.addr_ph = 1'b0;
            end
            if (!r.master) begin
              n.tx = (r.wk == WK_DRW);
            end
          end
        end
      end
      default: begin
      end
    endcase
    if (start_det && r.st != ST_MSTART) begin
      if (mid_byte) begin
        n.bus_fault = 1'b1;
      end
      if (!r.master) begin
        n.st = ST_XFER;
        n.cnt = BIT_ZERO;
        n.addr_ph = 1'b1;
        n.tx = 1'b0;
        n.sda_oe = 1'b0;
        n.scl_oe = 1'b0;
        n.hdr_ok = 1'b0;
        n.hit_pend = 1'b0;
        n.post_wait = 1'b0;
        n.post_ign = 1'b0;
      end
    end
    if (stop_det && r.st != ST_MSTOP) begin
      if (mid_byte) begin
        n.bus_fault = 1'b1;
      end else if (r.sel && !r.master) begin
        n.stop_seen = 1'b1;
      end
      if (!r.master || mid_byte) begin
        n.st = ST_IDLE;
        n.master = 1'b0;
        n.sda_oe = 1'b0;
        n.scl_oe = 1'b0;
        n.sel = 1'b0;
        n.ten_done = 1'b0;
        n.hit_pend = 1'b0;
        n.post_wait = 1'b0;
        n.post_ign = 1'b0;
      end
    end
    if (!block_on) begin
      n = '0;
    end
    n.event_p = n.address_hit || n.byte_done || n.stop_seen || n.bus_fault ||
                n.no_reply || n.start_sent || n.ev_hold;
    n.irq = n.event_p && irq_on;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign scl_o = r.line_lo;
  assign scl_oe = r.scl_oe;
  assign sda_o = r.line_lo;
  assign sda_oe = r.sda_oe;
  assign dr_rdata = r.dr;
  assign master_role_flag = r.master;
  assign address_hit_flag = r.address_hit;
  assign event_pending_flag = r.event_p;
  assign byte_done_flag = r.byte_done;
  assign stop_seen_flag = r.stop_seen;
  assign bus_fault_flag = r.bus_fault;
  assign no_reply_flag = r.no_reply;
  assign start_sent_flag = r.start_sent;
  assign tx_mode = r.tx;
  assign bus_busy = r.busy;
  assign irq = r.irq;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  AST_IRQ_FOLLOWS: assert property (##1 (irq == (r.event_p && $past(irq_on))))
    else $error("irq does not follow pending event and enable");
  AST_WAIT_HOLDS_SCL: assert property ((r.st == ST_WAIT) |-> r.scl_oe)
    else $error("scl released while waiting for software");
  AST_WAIT_FOR_WRITE: assert property ((r.st == ST_WAIT && r.wk == WK_DRW && !dr_write &&
      !start_req && !stop_req && block_on && !start_det && !stop_det) |=> (r.st == ST_WAIT))
    else $error("left transmit wait without a data write");
  AST_IDLE_SLAVE: assert property ((r.st == ST_IDLE) |-> !r.master)
    else $error("master role while idle");
  AST_HIT_EVENT: assert property ($rose(r.address_hit) |-> (r.event_p && r.sel))
    else $error("address hit without pending event");
  AST_STOP_FLAG: assert property ((stop_det && r.sel && !r.master && !mid_byte && block_on &&
      r.st != ST_MSTOP) |=> r.stop_seen)
    else $error("stop after addressing not flagged");
  AST_START_SENT: assert property ($rose(r.start_sent) |->
      (r.master && r.scl_oe && r.sda_oe && r.st == ST_WAIT))
    else $error("start flag without start driven");
  AST_MID_FAULT: assert property ((start_det && mid_byte && block_on) |=>
      (r.bus_fault && r.event_p))
    else $error("mid-byte start not flagged");
  AST_NACK_FLAG: assert property ((r.st == ST_XFER && r.tx && scl_rise && r.cnt == BIT_ACK &&
      sda_in && block_on && !start_det && !stop_det) |=> (r.no_reply && r.event_p))
    else $error("missing acknowledge not flagged");
  AST_RELEASE: assert property ((r.st == ST_WAIT && !r.master && r.byte_done && stop_req &&
      block_on) |=> (!r.scl_oe && !r.sda_oe))
    else $error("lines not released on stop during byte done");

  COV_ADDR_HIT: cover property ($rose(r.address_hit));
  COV_START_SENT: cover property ($rose(r.start_sent));
  COV_STOP_SEEN: cover property ($rose(r.stop_seen));
endmodule : i2cs_core
`default_nettype wire

/* core/i2cs_pkg.sv */
// Shared constants, modes and state type of the I2C byte sequencer
package i2cs_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  localparam int HALF_STD = CLK_HZ / (2 * SCL_STD_HZ);
  localparam int HALF_FAST = CLK_HZ / (2 * SCL_FAST_HZ);
  localparam logic [1:0] SPD_FAST = 2'h1;
  localparam logic [4:0] HDR10 = 5'h1e;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_POST = 4'h9;
  localparam logic [1:0] PH_REL = 2'h0;
  localparam logic [1:0] PH_MID = 2'h1;
  localparam logic [1:0] PH_END = 2'h2;
  localparam logic [1:0] WK_SR1 = 2'h0;
  localparam logic [1:0] WK_DRR = 2'h1;
  localparam logic [1:0] WK_DRW = 2'h2;
  localparam logic [1:0] WK_CRW = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_IGNORE, ST_XFER, ST_WAIT, ST_MSTART, ST_MSTOP}
    i2cs_state_type;
endpackage : i2cs_pkg

/* core/i2cs_line_mon.sv */
// Start, stop and SCL edge detector on the bus lines
`timescale 1ns/100ps
`default_nettype none
module i2cs_line_mon
  import i2cs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic start_det,
  output logic stop_det,
  output logic scl_rise,
  output logic scl_fall
);
  typedef struct packed {
    logic scl_d;
    logic sda_d;
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } i2cs_mon_type;

  i2cs_mon_type r, n;

  always_comb begin
    n = r;
    n.scl_d = scl_in;
    n.sda_d = sda_in;
    n.start = r.scl_d && scl_in && r.sda_d && !sda_in;
    n.stop = r.scl_d && scl_in && !r.sda_d && sda_in;
    n.rise = !r.scl_d && scl_in;
    n.fall = r.scl_d && !scl_in;
  end

  // Idle bus is high on both lines, so no false edge after reset
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '{scl_d: 1'b1, sda_d: 1'b1, default: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign start_det = r.start;
  assign stop_det = r.stop;
  assign scl_rise = r.rise;
  assign scl_fall = r.fall;
endmodule : i2cs_line_mon
`default_nettype wire

/* core/i2cs_scl_div.sv */
// Half-period tick generator for the master SCL
`timescale 1ns/100ps
`default_nettype none
module i2cs_scl_div
  import i2cs_pkg::*;
#(
  parameter int HALF_STD_CYC = HALF_STD,
  parameter int HALF_FAST_CYC = HALF_FAST
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic [1:0] bus_speed_bits,
  output logic tick
);
  localparam int CW = $clog2(HALF_STD_CYC + 1);

  if (HALF_FAST_CYC < 1 || HALF_STD_CYC < HALF_FAST_CYC) begin : g_chk
    $error("SCL divider counts out of range");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } i2cs_div_type;

  i2cs_div_type r, n;
  logic [CW-1:0] lim;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    lim = (bus_speed_bits == SPD_FAST) ? CW'(HALF_FAST_CYC - 1) : CW'(HALF_STD_CYC - 1);
    // Count clears to zero while a slave stretches, so high time is never cut short
    if (!run) begin
      n.cnt = '0;
    end else if (r.cnt >= lim) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;
endmodule : i2cs_scl_div
`default_nettype wire

/* test/i2cs_bus_model.sv */
// Far side of the bus: a model master that clocks bytes and a model slave that acks
`timescale 1ns/100ps
`default_nettype none
module i2cs_bus_model #(
  parameter int HALF = 8
) (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  logic m_scl = 1'b0;
  logic m_sda = 1'b0;
  logic a_scl = 1'b0;
  logic a_sda = 1'b0;
  logic ack_on = 1'b0;
  logic scl_d = 1'b1;
  logic sda_d = 1'b1;
  logic [7:0] rx_last = 8'h00;
  int slow = 0;
  int cnt = 0;
  int hold = 0;
  assign scl_pull = m_scl | a_scl;
  assign sda_pull = m_sda | a_sda;
  // Slave side: shift on rises, ack in slot nine, optional stretch after it
  always @(posedge clock) begin
    scl_d <= scl;
    sda_d <= sda;
    if (scl && scl_d && sda_d !== sda) begin
      cnt <= 0;
    end else if (scl && !scl_d) begin
      cnt <= cnt + 1;
      if (cnt < 8) begin
        rx_last <= {rx_last[6:0], sda};
      end
    end else if (!scl && scl_d && cnt == 8) begin
      a_sda <= ack_on;
    end else if (!scl && scl_d && cnt == 9) begin
      a_sda <= 1'b0;
      cnt <= 0;
      a_scl <= (slow > 0);
      hold <= slow;
    end
    if (hold > 0) begin
      hold <= hold - 1;
    end
    if (hold == 1) begin
      a_scl <= 1'b0;
    end
  end
  task automatic gap();
    repeat (HALF) @(posedge clock);
  endtask : gap
  // Bounded, so a clock held low for good cannot hang the run
  task automatic rise();
    int n;
    n = 0;
    m_scl <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (scl !== 1'b1 && n < 5000);
  endtask : rise
  task automatic start_cond();
    m_sda <= 1'b1;
    gap();
    m_scl <= 1'b1;
    gap();
  endtask : start_cond
  task automatic clk_bit(input logic b, output logic s);
    m_sda <= ~b;
    gap();
    rise();
    s = sda;
    gap();
    m_scl <= 1'b1;
  endtask : clk_bit
  task automatic put_byte(input logic [7:0] d, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    acked = ~s;
  endtask : put_byte
  task automatic stop_cond();
    m_sda <= 1'b1;
    gap();
    rise();
    gap();
    m_sda <= 1'b0;
    gap();
  endtask : stop_cond
endmodule : i2cs_bus_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the I2C byte sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import i2cs_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic block_on = 1'b0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic ack_en = 1'b1;
  logic gc_en = 1'b0;
  logic irq_on = 1'b1;
  logic [1:0] bus_speed_bits = SPD_FAST;
  logic sr1_read = 1'b0;
  logic sr2_read = 1'b0;
  logic dr_read = 1'b0;
  logic dr_write = 1'b0;
  logic cr_write = 1'b0;
  logic [7:0] dr_wdata = 8'h00;
  wire scl;
  wire sda;
  logic m_scl, m_sda, scl_o, scl_oe, sda_o, sda_oe, tx_mode, bus_busy, irq;
  logic master_role_flag, address_hit_flag, event_pending_flag, byte_done_flag;
  logic stop_seen_flag, bus_fault_flag, no_reply_flag, start_sent_flag;
  logic [7:0] dr_rdata;
  int error_cnt = 0;
  int checked = 0;
  assign scl = ~((scl_oe & ~scl_o) | m_scl);
  assign sda = ~((sda_oe & ~sda_o) | m_sda);
  always #20 clock = ~clock;
  i2cs_core #(.HALF_STD_CYC(4), .HALF_FAST_CYC(2)) dut (
    .clock(clock), .reset(reset), .block_on(block_on), .start_req(start_req),
    .stop_req(stop_req), .ack_en(ack_en), .gc_en(gc_en), .irq_on(irq_on),
    .ten_bit_mode(1'b0), .bus_speed_bits(bus_speed_bits), .own_addr(10'h05a),
    .sr1_read(sr1_read), .sr2_read(sr2_read), .dr_read(dr_read), .dr_write(dr_write),
    .dr_wdata(dr_wdata), .cr_write(cr_write), .scl_in(scl), .sda_in(sda),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .dr_rdata(dr_rdata),
    .master_role_flag(master_role_flag), .address_hit_flag(address_hit_flag),
    .event_pending_flag(event_pending_flag), .byte_done_flag(byte_done_flag),
    .stop_seen_flag(stop_seen_flag), .bus_fault_flag(bus_fault_flag),
    .no_reply_flag(no_reply_flag), .start_sent_flag(start_sent_flag),
    .tx_mode(tx_mode), .bus_busy(bus_busy), .irq(irq));
  i2cs_bus_model #(.HALF(8)) bus (.clock(clock), .scl(scl), .sda(sda),
    .scl_pull(m_scl), .sda_pull(m_sda));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chkb(input string w, input logic e, input logic g);
    chk(w, {7'h00, e}, {7'h00, g});
  endtask : chkb
  // Order: sr1, sr2, dr read, dr write, cr write
  task automatic strobe(input logic [4:0] m);
    {sr1_read, sr2_read, dr_read, dr_write, cr_write} <= m;
    @(posedge clock);
    {sr1_read, sr2_read, dr_read, dr_write, cr_write} <= 5'h00;
    repeat (2) @(posedge clock);
  endtask : strobe
  task automatic wait_ev();
    int n;
    n = 0;
    while (event_pending_flag !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    chkb("event_pending_flag", 1'b1, event_pending_flag);
    repeat (2) @(posedge clock);
  endtask : wait_ev
  task automatic held();
    repeat (40) @(posedge clock);
    chkb("scl_oe held", 1'b1, scl_oe);
  endtask : held
  task automatic master_addr(input logic [7:0] adr);
    start_req <= 1'b1;
    wait_ev();
    chkb("start_sent_flag", 1'b1, start_sent_flag);
    chkb("master_role_flag", 1'b1, master_role_flag);
    start_req <= 1'b0;
    held();
    strobe(5'h10);
    dr_wdata <= adr;
    strobe(5'h02);
    wait_ev();
    held();
  endtask : master_addr
  task automatic master_stop();
    int n;
    n = 0;
    strobe(5'h10);
    stop_req <= 1'b1;
    while (master_role_flag !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    stop_req <= 1'b0;
    repeat (8) @(posedge clock);
    chkb("master_role_flag", 1'b0, master_role_flag);
    chkb("scl_oe", 1'b0, scl_oe);
    chkb("sda_oe", 1'b0, sda_oe);
    chkb("bus_busy", 1'b0, bus_busy);
  endtask : master_stop
  task automatic test_reset();
    chkb("master_role_flag", 1'b0, master_role_flag);
    chkb("scl_oe", 1'b0, scl_oe);
    chkb("event_pending_flag", 1'b0, event_pending_flag);
    $display("test reset done");
  endtask : test_reset
  task automatic test_slave_rx();
    logic a;
    fork
      begin
        bus.start_cond();
        bus.put_byte(8'hb4, a);
        chkb("address ack", 1'b1, a);
        bus.put_byte(8'h3c, a);
        chkb("data ack", 1'b1, a);
        bus.put_byte(8'h96, a);
        chkb("final nack", 1'b0, a);
        bus.stop_cond();
      end
      begin
        wait_ev();
        chkb("address_hit_flag", 1'b1, address_hit_flag);
        chkb("irq", 1'b1, irq);
        chk("address byte", 8'hb4, dr_rdata);
        held();
        strobe(5'h10);
        wait_ev();
        chkb("byte_done_flag", 1'b1, byte_done_flag);
        held();
        strobe(5'h10);
        chk("dr_rdata", 8'h3c, dr_rdata);
        ack_en <= 1'b0;
        strobe(5'h04);
        wait_ev();
        chkb("byte_done_flag", 1'b1, byte_done_flag);
        held();
        strobe(5'h10);
        chk("dr_rdata", 8'h96, dr_rdata);
        ack_en <= 1'b1;
        strobe(5'h04);
        wait_ev();
        chkb("stop_seen_flag", 1'b1, stop_seen_flag);
        strobe(5'h08);
        chkb("event_pending_flag", 1'b0, event_pending_flag);
        chkb("irq", 1'b0, irq);
      end
    join
    $display("test slave receive done");
  endtask : test_slave_rx
  task automatic test_slave_miss();
    logic a;
    bus.start_cond();
    bus.put_byte(8'h22, a);
    chkb("foreign address ack", 1'b0, a);
    bus.stop_cond();
    repeat (4) @(posedge clock);
    chkb("event_pending_flag", 1'b0, event_pending_flag);
    chkb("stop_seen_flag", 1'b0, stop_seen_flag);
    gc_en <= 1'b1;
    bus.start_cond();
    fork
      begin
        bus.put_byte(8'h00, a);
        chkb("general call ack", 1'b1, a);
      end
      begin
        wait_ev();
        chkb("address_hit_flag", 1'b1, address_hit_flag);
        held();
        strobe(5'h10);
      end
    join
    bus.stop_cond();
    chkb("stop_seen_flag", 1'b1, stop_seen_flag);
    strobe(5'h08);
    gc_en <= 1'b0;
    $display("test address mismatch done");
  endtask : test_slave_miss
  task automatic test_mid_stop();
    logic a;
    bus.start_cond();
    repeat (3) bus.clk_bit(1'b1, a);
    bus.stop_cond();
    repeat (4) @(posedge clock);
    chkb("bus_fault_flag", 1'b1, bus_fault_flag);
    chkb("sda_oe", 1'b0, sda_oe);
    strobe(5'h08);
    chkb("bus_fault_flag", 1'b0, bus_fault_flag);
    $display("test misplaced stop done");
  endtask : test_mid_stop
  task automatic test_master_tx();
    bus_speed_bits <= 2'h0;
    bus.ack_on = 1'b1;
    bus.slow = 30;
    master_addr(8'ha6);
    chk("address on wire", 8'ha6, bus.rx_last);
    strobe(5'h10);
    strobe(5'h01);
    held();
    dr_wdata <= 8'h5c;
    strobe(5'h02);
    wait_ev();
    chkb("byte_done_flag", 1'b1, byte_done_flag);
    chk("data on wire", 8'h5c, bus.rx_last);
    master_stop();
    $display("test master transmit done");
  endtask : test_master_tx
  task automatic test_master_nack();
    bus_speed_bits <= SPD_FAST;
    bus.ack_on = 1'b0;
    bus.slow = 0;
    master_addr(8'ha6);
    chkb("no_reply_flag", 1'b1, no_reply_flag);
    repeat (20) @(posedge clock);
    strobe(5'h08);
    chkb("no_reply_flag", 1'b0, no_reply_flag);
    master_stop();
    $display("test master nack done");
  endtask : test_master_nack
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    block_on <= 1'b1;
    repeat (2) @(posedge clock);
    test_reset();
    test_slave_rx();
    test_slave_miss();
    test_mid_stop();
    test_master_tx();
    test_master_nack();
    test_done();
  end
  // Whole run needs a few thousand cycles; this is ample margin
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen timeout");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
